//--- ebr_pkg.sv
package ebr_pkg;

    // widths
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;

    // parameter block fetch: two words per bus ownership period,
    // 8 words (4 periods) wide, 6 words (3 periods) narrow
    localparam logic [2:0] LAST_WORD_WIDE   = 3'h7;
    localparam logic [2:0] LAST_WORD_NARROW = 3'h5;
    localparam logic [1:0] WORD_BYTES_SH    = 2'h0;

    // word positions inside the parameter block
    localparam logic [2:0] WIDE_MODE_WORD  = 3'h0;
    localparam logic [2:0] WIDE_RX_WORD    = 3'h5;
    localparam logic [2:0] WIDE_TX_WORD    = 3'h6;
    localparam logic [2:0] NAR_MODE_WORD   = 3'h0;
    localparam logic [2:0] NAR_RX_WORD     = 3'h2;
    localparam logic [2:0] NAR_TX_WORD     = 3'h3;
    localparam int         WIDE_RX_LEN_LSB = 20;
    localparam int         WIDE_TX_LEN_LSB = 28;
    localparam int         NAR_LEN_LSB     = 29;
    localparam int         NAR_BASE_W      = 24;

    // descriptor entry size and ring length caps (log2 entries)
    localparam logic [31:0] ENTRY_WIDE     = 32'h0000_0010;
    localparam logic [31:0] ENTRY_NARROW   = 32'h0000_0008;
    localparam logic [3:0]  LEN_CAP_WIDE   = 4'h9;
    localparam logic [3:0]  LEN_CAP_NARROW = 4'h7;

    // reset values
    localparam logic [16:0] POLL_DEFAULT   = 17'h1_0000;
    localparam logic [15:0] LEN_RESET      = 16'h0001;

    // mode register bits
    localparam int MODE_RX_DIS = 0;
    localparam int MODE_TX_DIS = 1;

    // primary control/status bit positions
    localparam int ST_BIT_INIT   = 0;
    localparam int ST_BIT_RUN    = 1;
    localparam int ST_BIT_STOP   = 2;
    localparam int ST_BIT_TX_ACT = 4;
    localparam int ST_BIT_RX_ACT = 5;
    localparam int ST_BIT_IRQ_EN = 6;
    localparam int ST_BIT_DONE   = 8;

    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_FETCH = 3'b001,
        S_WAIT  = 3'b010,
        S_GAP   = 3'b011,
        S_LOAD  = 3'b100,
        S_RUN   = 3'b101,
        S_STOP  = 3'b110
    } ebr_state_e;

    typedef enum logic [2:0] {
        DS_MODE    = 3'b000,
        DS_RX_BASE = 3'b001,
        DS_TX_BASE = 3'b010,
        DS_RX_LEN  = 3'b011,
        DS_TX_LEN  = 3'b100,
        DS_POLL    = 3'b101
    } ebr_dsel_e;

    typedef struct packed {
        logic [15:0]       idx;
        logic [ADDR_W-1:0] cur;
        logic [ADDR_W-1:0] nxt;
    } ebr_ptr_s;

    typedef struct packed {
        logic              req;
        logic [ADDR_W-1:0] addr;
    } ebr_mreq_s;

endpackage

//--- ebr_buffer_manager.sv
`timescale 1ns/10ps
// Functional notes
// - state machine steps at half clock rate
// - initialize request fetches parameter block
// - two words per bus ownership period
// - set done flag, interrupt if enabled
// - block address from low/high halves
// - direct programming; fetch overwrites it
// - mode disable bits gate rx/tx active
// - stop then run reloads ring pointers
// - entry is 16 or 8 bytes
// - fetched lengths capped, direct up to 65535
// - descriptor ownership bit one means device
// - only owner may write a descriptor
// - load current and next from ring base
// - structure select picks 16 or 32 bit
// - rx active bit 5, tx bit 4
// - poll interval defaults to 65536 periods
module ebr_buffer_manager
    import ebr_pkg::*;
#(
    parameter logic [16:0] P_POLL_DEFAULT = ebr_pkg::POLL_DEFAULT
)(
    input  wire logic                   i_clk,
    input  wire logic                   i_srst,
    input  wire logic                   i_init_req,
    input  wire logic                   i_run_request,
    input  wire logic                   i_stop_req,
    input  wire logic                   i_irq_enable,
    input  wire logic                   i_wide_structures_select,
    input  wire logic [15:0]            i_param_addr_low_reg,
    input  wire logic [15:0]            i_param_addr_high_reg,
    input  wire logic                   i_dir_we,
    input  wire ebr_pkg::ebr_dsel_e     i_dir_sel,
    input  wire logic [31:0]            i_dir_data,
    input  wire logic                   i_done_clr,
    input  wire logic                   i_rx_fault,
    input  wire logic                   i_tx_fault,
    input  wire logic                   i_rx_advance,
    input  wire logic                   i_tx_advance,
    input  wire logic                   i_mem_ack,
    input  wire logic [31:0]            i_mem_rdata,
    output ebr_pkg::ebr_mreq_s          o_mem,
    output logic                        o_arb_req,
    output logic                        o_setup_done_flag,
    output logic                        o_irq,
    output logic                        o_receiver_active,
    output logic                        o_transmitter_active,
    output logic [15:0]                 o_primary_ctrl_status_reg,
    output logic [15:0]                 o_mode_reg,
    output logic [16:0]                 o_poll_interval_reg,
    output ebr_pkg::ebr_ptr_s           o_rx_ptr,
    output ebr_pkg::ebr_ptr_s           o_tx_ptr
);
    import ebr_pkg::*;

    if (P_POLL_DEFAULT == 17'h0_0000)
    begin : g_chk
        $error("poll default must be non-zero");
    end

    // ring length from a log2 field, clamped to the structure's cap
    function automatic logic [15:0] ring_len(input logic [3:0] f,
                                             input logic [3:0] cap);
        logic [3:0] e;
        e = (f > cap) ? cap : f;
        return 16'h0001 << e;
    endfunction

    // next entry address; the last entry points back at the base
    function automatic ebr_ptr_s ptr_step(input ebr_ptr_s p,
                                          input logic [15:0] len,
                                          input logic [31:0] base,
                                          input logic [31:0] esz);
        ebr_ptr_s r;
        logic     last;
        last = (len <= 16'h0001) || (p.idx >= len - 16'h0001);
        r.idx = last ? 16'h0000 : p.idx + 16'h0001;
        r.cur = last ? base : p.cur + esz;
        r.nxt = ((len <= 16'h0001) || (r.idx == len - 16'h0001))
              ? base : r.cur + esz;
        return r;
    endfunction

    function automatic ebr_ptr_s ptr_load(input logic [15:0] len,
                                          input logic [31:0] base,
                                          input logic [31:0] esz);
        ebr_ptr_s r;
        r.idx = 16'h0000;
        r.cur = base;
        r.nxt = (len <= 16'h0001) ? base : base + esz;
        return r;
    endfunction

    ebr_state_e  state;
    ebr_state_e  next_state;
    logic        ce;
    logic        init_pend;
    logic        run_pend;
    logic        stop_pend;
    logic        fetched;
    logic [2:0]  word_idx;
    logic        word_ok;
    logic [31:0] word;
    logic [31:0] rx_base;
    logic [31:0] tx_base;
    logic [15:0] rx_len;
    logic [15:0] tx_len;
    logic        rx_shut;
    logic        tx_shut;
    logic [31:0] mem_addr;

    // selection and decode
    wire         wide      = i_wide_structures_select;
    wire [31:0]  esz       = wide ? ENTRY_WIDE : ENTRY_NARROW;
    wire [3:0]   len_cap   = wide ? LEN_CAP_WIDE : LEN_CAP_NARROW;
    wire [2:0]   last_word = wide ? LAST_WORD_WIDE : LAST_WORD_NARROW;
    wire [31:0]  blk_base  = {i_param_addr_high_reg,
                              i_param_addr_low_reg};
    wire         apply     = ce && state == S_WAIT && word_ok;
    wire         run_now   = state == S_RUN;
    wire [2:0]   mode_word = wide ? WIDE_MODE_WORD : NAR_MODE_WORD;
    wire [2:0]   rx_word   = wide ? WIDE_RX_WORD : NAR_RX_WORD;
    wire [2:0]   tx_word   = wide ? WIDE_TX_WORD : NAR_TX_WORD;
    wire [3:0]   rx_lfield = wide ? word[WIDE_RX_LEN_LSB +: 4]
                                  : {1'b0, word[NAR_LEN_LSB +: 3]};
    wire [3:0]   tx_lfield = wide ? word[WIDE_TX_LEN_LSB +: 4]
                                  : {1'b0, word[NAR_LEN_LSB +: 3]};
    wire [31:0]  word_base = wide ? word
                           : {8'h00, word[NAR_BASE_W-1:0]};

    // half-rate enable for the state machine
    always_ff @(posedge i_clk)
    begin
        ce <= i_srst ? 1'b0 : ~ce;
    end

    // requests arrive at full rate and wait for the next step;
    // a new pulse in the consuming cycle is kept
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            init_pend <= 1'b0;
            run_pend  <= 1'b0;
            stop_pend <= 1'b0;
        end
        else
        begin
            init_pend <= i_init_req | (init_pend & ~ce);
            run_pend  <= i_run_request | (run_pend & ~ce);
            stop_pend <= i_stop_req | (stop_pend & ~ce);
        end
    end

    // init beats stop beats run; run from idle or stop goes straight to load
    always_comb
    begin
        next_state = state;
        unique case (state)
            S_IDLE:  if (run_pend) next_state = S_LOAD;
            S_FETCH: next_state = S_WAIT;
            S_WAIT:
                if (word_ok)
                    next_state = (word_idx == last_word) ? S_LOAD
                               : word_idx[0] ? S_GAP : S_FETCH;
            S_GAP:   next_state = S_FETCH;
            S_LOAD:  next_state = S_RUN;
            S_RUN:   next_state = S_RUN;
            S_STOP:  if (run_pend) next_state = S_LOAD;
        endcase
        if (stop_pend)
            next_state = S_STOP;
        if (init_pend)
            next_state = S_FETCH;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            state <= S_IDLE;
        else if (ce)
            state <= next_state;
    end

    // fetch sequencing: word counter, address, fetched marker
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            word_idx    <= 3'h0;
            mem_addr    <= 32'h0000_0000;
            fetched     <= 1'b0;
        end
        else if (ce)
        begin
            if (init_pend)
            begin
                word_idx <= 3'h0;
                fetched  <= 1'b1;
            end
            else if (state == S_STOP || state == S_IDLE)
                fetched  <= 1'b0;
            else if (apply)
                word_idx <= word_idx + 3'h1;
            if (state == S_FETCH)
                mem_addr <= blk_base
                          + {27'h0, word_idx, WORD_BYTES_SH};
        end
    end

    // capture each fetched word; ack may land on either phase
    always_ff @(posedge i_clk)
    begin
        if (i_srst || state != S_WAIT)
            word_ok <= 1'b0;
        else if (i_mem_ack && !word_ok)
        begin
            word_ok <= 1'b1;
            word    <= i_mem_rdata;
        end
    end

    // bus ownership drops between each pair of words
    // one driver for the whole request struct; address from a flop
    assign o_mem = '{req:  state == S_WAIT && !word_ok,
                     addr: mem_addr};
    assign o_arb_req = state == S_FETCH || state == S_WAIT;

    // operating registers: fetched words overwrite direct writes
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            o_mode_reg          <= 16'h0000;
            rx_base             <= 32'h0000_0000;
            tx_base             <= 32'h0000_0000;
            rx_len              <= LEN_RESET;
            tx_len              <= LEN_RESET;
            o_poll_interval_reg <= P_POLL_DEFAULT;
        end
        else if (apply)
        begin
            if (word_idx == mode_word)
                o_mode_reg <= word[15:0];
            if (word_idx == mode_word && wide)
            begin
                rx_len <= ring_len(rx_lfield, len_cap);
                tx_len <= ring_len(tx_lfield, len_cap);
            end
            if (word_idx == rx_word)
                rx_base <= word_base;
            if (word_idx == rx_word && !wide)
                rx_len  <= ring_len(rx_lfield, len_cap);
            if (word_idx == tx_word)
                tx_base <= word_base;
            if (word_idx == tx_word && !wide)
                tx_len  <= ring_len(tx_lfield, len_cap);
        end
        else if (ce && init_pend)
            o_poll_interval_reg <= P_POLL_DEFAULT;
        else if (i_dir_we)
        begin
            unique case (i_dir_sel)
                DS_MODE:    o_mode_reg <= i_dir_data[15:0];
                DS_RX_BASE: rx_base    <= i_dir_data;
                DS_TX_BASE: tx_base    <= i_dir_data;
                DS_RX_LEN:  rx_len     <= i_dir_data[15:0];
                DS_TX_LEN:  tx_len     <= i_dir_data[15:0];
                DS_POLL:    o_poll_interval_reg <= i_dir_data[16:0];
                default:    o_mode_reg <= o_mode_reg;
            endcase
        end
    end

    // ring pointers: reload on every (re)start, step on advance
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            o_rx_ptr <= '0;
            o_tx_ptr <= '0;
        end
        else if (ce && state == S_LOAD && next_state == S_RUN)
        begin
            o_rx_ptr <= ptr_load(rx_len, rx_base, esz);
            o_tx_ptr <= ptr_load(tx_len, tx_base, esz);
        end
        // an advance means the owner handed the entry back;
        // nothing here writes a descriptor field
        else if (run_now)
        begin
            if (i_rx_advance)
                o_rx_ptr <= ptr_step(o_rx_ptr, rx_len, rx_base,
                                     esz);
            if (i_tx_advance)
                o_tx_ptr <= ptr_step(o_tx_ptr, tx_len, tx_base,
                                     esz);
        end
    end

    // faults shut a section until the next load; fault wins over clear
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            rx_shut <= 1'b0;
            tx_shut <= 1'b0;
        end
        else
        begin
            rx_shut <= i_rx_fault | (rx_shut & ~(state == S_LOAD));
            tx_shut <= i_tx_fault | (tx_shut & ~(state == S_LOAD));
        end
    end

    // status flags; a new completion beats a software clear
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            o_setup_done_flag    <= 1'b0;
            o_irq                <= 1'b0;
            o_receiver_active    <= 1'b0;
            o_transmitter_active <= 1'b0;
        end
        else
        begin
            o_setup_done_flag <= (ce && state == S_LOAD && fetched
                                 && next_state == S_RUN)
                              | (o_setup_done_flag & ~i_done_clr);
            o_irq <= o_setup_done_flag & i_irq_enable;
            o_receiver_active <= run_now && !rx_shut
                              && !o_mode_reg[MODE_RX_DIS];
            o_transmitter_active <= run_now && !tx_shut
                              && !o_mode_reg[MODE_TX_DIS];
        end
    end

    // status word is a plain view of registered state plus the irq enable input
    always_comb
    begin
        o_primary_ctrl_status_reg              = 16'h0000;
        o_primary_ctrl_status_reg[ST_BIT_INIT] = fetched && !run_now;
        o_primary_ctrl_status_reg[ST_BIT_RUN]  = run_now;
        o_primary_ctrl_status_reg[ST_BIT_STOP] = state == S_STOP;
        o_primary_ctrl_status_reg[ST_BIT_TX_ACT] =
            o_transmitter_active;
        o_primary_ctrl_status_reg[ST_BIT_RX_ACT] = o_receiver_active;
        o_primary_ctrl_status_reg[ST_BIT_IRQ_EN] = i_irq_enable;
        o_primary_ctrl_status_reg[ST_BIT_DONE] = o_setup_done_flag;
    end

    property p_half_rate;
        @(posedge i_clk) disable iff (i_srst)
        (state != $past(state)) |-> $past(ce);
    endproperty
    a_half_rate: assert property (p_half_rate)
        else $error("state moved off the half-rate step");

    property p_init_fetch;
        @(posedge i_clk) disable iff (i_srst)
        (ce && init_pend) |=> state == S_FETCH ##2 o_mem.req;
    endproperty
    a_init_fetch: assert property (p_init_fetch)
        else $error("initialize did not start a fetch");

    property p_pair_gap;
        @(posedge i_clk) disable iff (i_srst)
        (state == S_GAP) |-> word_idx[0] == 1'b0 && !o_arb_req;
    endproperty
    a_pair_gap: assert property (p_pair_gap)
        else $error("bus released off a word pair");

    property p_done;
        @(posedge i_clk) disable iff (i_srst)
        (ce && state == S_LOAD && fetched && !init_pend && !stop_pend)
        |=> o_setup_done_flag ##1 (o_irq == i_irq_enable);
    endproperty
    a_done: assert property (p_done)
        else $error("done flag or interrupt missing");

    property p_addr;
        @(posedge i_clk) disable iff (i_srst)
        (ce && state == S_FETCH && !init_pend && !stop_pend)
        |=> o_mem.addr == {i_param_addr_high_reg, i_param_addr_low_reg}
            + {27'h0, word_idx, 2'h0};
    endproperty
    a_addr: assert property (p_addr)
        else $error("fetch address wrong");

    property p_rx_on;
        @(posedge i_clk) disable iff (i_srst)
        o_receiver_active |-> !$past(o_mode_reg[MODE_RX_DIS])
                              && $past(state) == S_RUN;
    endproperty
    a_rx_on: assert property (p_rx_on)
        else $error("receiver active while disabled");

    property p_reload;
        @(posedge i_clk) disable iff (i_srst)
        (ce && state == S_LOAD && !init_pend && !stop_pend)
        |=> o_rx_ptr.cur == rx_base && o_tx_ptr.cur == tx_base
            && o_rx_ptr.idx == 16'h0000;
    endproperty
    a_reload: assert property (p_reload)
        else $error("pointers not reloaded from ring base");

    property p_wrap;
        @(posedge i_clk) disable iff (i_srst)
        (run_now && i_rx_advance && !ce && o_rx_ptr.idx == rx_len - 16'h1)
        |=> o_rx_ptr.cur == rx_base && o_rx_ptr.idx == 16'h0000;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("ring did not wrap to base");

    property p_step;
        @(posedge i_clk) disable iff (i_srst)
        (run_now && i_tx_advance && !ce && o_tx_ptr.idx + 16'h1 < tx_len)
        |=> o_tx_ptr.cur == $past(o_tx_ptr.cur) + $past(esz);
    endproperty
    a_step: assert property (p_step)
        else $error("entry step size wrong");

endmodule

//--- ebr_host_mem.sv
`timescale 1ns/10ps
// host memory holding the parameter block, answering word reads
module ebr_host_mem
(
    input  wire logic        i_clk,
    input  wire logic        i_srst,
    input  wire logic        i_req,
    input  wire logic [31:0] i_addr,
    input  wire logic [3:0]  i_lat,
    output logic             o_ack,
    output logic [31:0]      o_rdata
);
    logic [31:0] mem [0:7];
    logic [3:0]  cnt;

    // one ack per request after i_lat wait cycles; data toggles outside
    // the ack so a stale word can never pass for a fresh one
    always_ff @(posedge i_clk)
    begin
        o_ack   <= 1'b0;
        o_rdata <= ~o_rdata;
        if (i_srst)
        begin
            cnt     <= 4'h0;
            o_rdata <= 32'hA5A5_A5A5;
        end
        else if (i_req && !o_ack)
        begin
            if (cnt == i_lat)
            begin
                o_ack   <= 1'b1;
                o_rdata <= mem[i_addr[4:2]]; // read only
                cnt     <= 4'h0;
            end
            else
                cnt <= cnt + 4'h1;
        end
    end
endmodule

//--- tb_ebr_buffer_manager.sv
`timescale 1ns/10ps
module tb_ebr_buffer_manager;
    import ebr_pkg::*;
    // short poll default, checked at reset and after each fetch
    localparam logic [16:0] POLL  = 17'h0_0040;
    localparam logic [31:0] PBASE = 32'h1234_5600;
    logic        clk, srst, init, run, stop, irqen, wide, dwe, dclr;
    logic        rxf, txf, rxa, txa, ack, arb, done, irq, rx_on, tx_on;
    logic        arb_q;
    ebr_dsel_e   dsel;
    logic [31:0] ddata, rdata;
    logic [3:0]  lat;
    logic [15:0] st, mode;
    logic [16:0] poll;
    ebr_mreq_s   mreq;
    ebr_ptr_s    rxp, txp;
    int          errors, num_checks, arbn, ackn;

    ebr_buffer_manager #(.P_POLL_DEFAULT(POLL)) dut (
        .i_clk(clk), .i_srst(srst), .i_init_req(init), .i_run_request(run),
        .i_stop_req(stop), .i_irq_enable(irqen),
        .i_wide_structures_select(wide),
        .i_param_addr_low_reg(PBASE[15:0]),
        .i_param_addr_high_reg(PBASE[31:16]),
        .i_dir_we(dwe), .i_dir_sel(dsel), .i_dir_data(ddata),
        .i_done_clr(dclr), .i_rx_fault(rxf), .i_tx_fault(txf),
        .i_rx_advance(rxa), .i_tx_advance(txa), .i_mem_ack(ack),
        .i_mem_rdata(rdata), .o_mem(mreq), .o_arb_req(arb),
        .o_setup_done_flag(done), .o_irq(irq), .o_receiver_active(rx_on),
        .o_transmitter_active(tx_on), .o_primary_ctrl_status_reg(st),
        .o_mode_reg(mode), .o_poll_interval_reg(poll),
        .o_rx_ptr(rxp), .o_tx_ptr(txp));

    ebr_host_mem host (.i_clk(clk), .i_srst(srst), .i_req(mreq.req),
        .i_addr(mreq.addr), .i_lat(lat), .o_ack(ack), .o_rdata(rdata));

    // free-running 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // counts ownership periods and checks each word address as it is taken
    always @(posedge clk)
    begin
        if (arb && !arb_q)
            arbn++;
        arb_q = arb;
        if (ack)
        begin
            chk("mem.addr", mreq.addr, PBASE + 32'(4 * ackn));
            ackn++;
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task report_and_stop;
        if (errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // bounded wait on one status bit
    task automatic wait_st(input int b);
        int k;
        for (k = 0; k < 3000 && st[b] !== 1'b1; k++)
            @(posedge clk);
        if (k == 3000)
        begin
            errors++;
            report_and_stop();
        end
    endtask

    task automatic adv(input logic tx);
        @(posedge clk);
        if (tx) txa <= 1'b1; else rxa <= 1'b1;
        @(posedge clk);
        txa <= 1'b0;
        rxa <= 1'b0;
        cyc(3);
    endtask

    // walk a whole ring from its base, checking every step and the wrap
    task automatic ring(input logic tx, input logic [31:0] base,
                        input logic [31:0] esz, input int len);
        ebr_ptr_s p;
        for (int i = 1; i <= len; i++) // in order
        begin
            adv(tx);
            p = tx ? txp : rxp;
            chk("ptr.cur", p.cur, base + esz * 32'(i % len));
            chk("ptr.nxt", p.nxt, base + esz * 32'((i+1) % len));
        end
    endtask

    task automatic dwr(input ebr_dsel_e s, input logic [31:0] d);
        @(posedge clk);
        dwe   <= 1'b1;
        dsel  <= s;
        ddata <= d;
        @(posedge clk);
        dwe <= 1'b0;
    endtask

    task automatic pulse_stop;
        @(posedge clk) stop <= 1'b1;
        @(posedge clk) stop <= 1'b0;
        wait_st(ST_BIT_STOP);
    endtask

    task automatic pulse_run;
        @(posedge clk) run <= 1'b1;
        @(posedge clk) run <= 1'b0;
        wait_st(ST_BIT_RUN);
        cyc(3);
    endtask

    // initialize through the parameter block and count bus activity
    task automatic fetch(input logic w, input logic [3:0] l,
                         input int words, input int periods);
        @(posedge clk) wide <= w;
        lat  <= l;
        dclr <= 1'b1;
        @(posedge clk) dclr <= 1'b0;
        arbn = 0;
        ackn = 0;
        @(posedge clk) init <= 1'b1; // no run before init
        @(posedge clk) init <= 1'b0;
        wait_st(ST_BIT_DONE);
        cyc(3);
        chk("periods", arbn, periods);
        chk("words", ackn, words);
        chk("poll", poll, POLL);
    endtask

    task automatic t_reset;
        chk("poll", poll, POLL);
        chk("done", done, 1'b0);
        chk("mode", mode, 16'h0000);
        chk("rx.cur", rxp.cur, 32'h0);
        chk("arb", arb, 1'b0);
    endtask

    task automatic t_wide;
        for (int i = 0; i < 8; i++) host.mem[i] = 32'h0;
        host.mem[0] = 32'hF030_0000; // rx len 8, tx len capped
        host.mem[5] = 32'h0010_0000; // 16-byte aligned
        host.mem[6] = 32'h0020_0000;
        irqen <= 1'b1;
        fetch(1'b1, 4'h5, 8, 4);
        chk("done", done, 1'b1);
        chk("irq", irq, 1'b1);
        chk("irq_en", st[ST_BIT_IRQ_EN], 1'b1);
        chk("rx.cur", rxp.cur, 32'h0010_0000);
        chk("rx.nxt", rxp.nxt, 32'h0010_0010);
        chk("tx.nxt", txp.nxt, 32'h0020_0010);
        chk("rx_on", st[ST_BIT_RX_ACT], 1'b1);
        chk("tx_on", st[ST_BIT_TX_ACT], 1'b1);
        chk("rx_on", rx_on, 1'b1);
        ring(1'b0, 32'h0010_0000, 32'h10, 8);
        ring(1'b1, 32'h0020_0000, 32'h10, 512);
    endtask

    task automatic t_restart;
        adv(1'b0);
        adv(1'b0);
        adv(1'b1);
        pulse_stop(); // own ring walk restarts at base
        cyc(2);
        chk("rx_on", rx_on, 1'b0);
        dwr(DS_MODE, 32'h0000_0001);
        pulse_run();
        chk("rx.cur", rxp.cur, 32'h0010_0000);
        chk("rx.nxt", rxp.nxt, 32'h0010_0010);
        chk("tx.cur", txp.cur, 32'h0020_0000);
        chk("done", done, 1'b1);
        chk("rx_on", rx_on, 1'b0);
        chk("tx_on", tx_on, 1'b1);
    endtask

    task automatic t_narrow;
        host.mem[0] = 32'h0000_0002; // transmitter off
        host.mem[2] = 32'h4000_3000;
        host.mem[3] = 32'h2000_4000;
        irqen <= 1'b0;
        fetch(1'b0, 4'h0, 6, 3);
        chk("mode", mode, 16'h0002); // fetch overwrites
        chk("irq", irq, 1'b0);
        chk("rx.nxt", rxp.nxt, 32'h0000_3008);
        chk("tx.cur", txp.cur, 32'h0000_4000);
        chk("tx_on", tx_on, 1'b0);
        chk("rx_on", rx_on, 1'b1);
        ring(1'b0, 32'h0000_3000, 32'h8, 4);
        ring(1'b1, 32'h0000_4000, 32'h8, 2);
        @(posedge clk) rxf <= 1'b1;
        @(posedge clk) rxf <= 1'b0;
        cyc(3);
        chk("rx_on", rx_on, 1'b0);
    endtask

    task automatic t_direct;
        pulse_stop();
        @(posedge clk) dclr <= 1'b1;
        @(posedge clk) dclr <= 1'b0;
        arbn = 0;
        dwr(DS_RX_BASE, 32'h0050_0000);
        dwr(DS_RX_LEN, 32'h0000_0003);
        dwr(DS_TX_BASE, 32'h0060_0000);
        dwr(DS_TX_LEN, 32'h0000_0002);
        dwr(DS_POLL, 32'h0000_0123);
        dwr(DS_MODE, 32'h0000_0000);
        pulse_run();
        chk("poll", poll, 17'h0_0123);
        chk("periods", arbn, 0);
        chk("done", done, 1'b0);
        chk("rx_on", rx_on, 1'b1);
        ring(1'b0, 32'h0050_0000, 32'h8, 3);
        ring(1'b1, 32'h0060_0000, 32'h8, 2);
    endtask

    // reset, then the scenarios in order
    initial
    begin
        {srst, init, run, stop, irqen, wide, dwe, dclr} = 8'h80;
        {rxf, txf, rxa, txa, arb_q} = 5'h00;
        dsel  = DS_MODE;
        ddata = 32'h0;
        lat   = 4'h0;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        cyc(2);
        t_reset();
        t_wide();
        t_restart();
        t_narrow();
        t_direct();
        report_and_stop();
    end
endmodule
